// *** common/hmd_pkg.sv ***
/*
 * Shared definitions of the host memory space decoder: configuration
 * offsets, field positions, reset values, decode windows and the
 * request and routing records that travel between the files.
 * Assumes a byte-wide configuration port and a 32-bit host address.
 */
package hmd_pkg;

	// Configuration offsets of the decoder registers.
	localparam logic [7:0] OFS_PAGE_C = 8'h80;
	localparam logic [7:0] OFS_PAGE_D = 8'h81;
	localparam logic [7:0] OFS_PAGE_E = 8'h82;
	localparam logic [7:0] OFS_PAGE_F = 8'h83;
	localparam logic [7:0] OFS_LTOP_LO = 8'h84;
	localparam logic [7:0] OFS_LTOP_HI = 8'h85;
	localparam logic [7:0] OFS_SMM_APIC = 8'h86;
	localparam logic [7:0] OFS_LAST_LO = 8'h88;
	localparam logic [7:0] OFS_LAST_HI = 8'h89;

	// Reset values.
	localparam logic [7:0] RST_PAGE = 8'h00;
	localparam logic [7:0] RST_PAGE_F = 8'h00;
	localparam logic [7:0] RST_LTOP_LO = 8'h00;
	localparam logic [7:0] RST_LTOP_HI = 8'hFF;
	localparam logic [7:0] RST_SMM_APIC = 8'h03;
	localparam logic [10:0] RST_LAST = 11'h004;

	// Writable masks; the other bits read as zero.
	localparam logic [7:0] MSK_PAGE_F = 8'h3F;
	localparam logic [7:0] MSK_LTOP_LO = 8'hF0;

	// Field positions of the page F, hole and SMRAM register.
	localparam int F_CTRL_POS = 4;
	localparam int HOLE_POS = 2;
	localparam int SMM_DATA_PCI_BIT = 1;
	localparam int AB_DRAM_BIT = 0;

	// Field positions of the SMM and APIC register.
	localparam int TSM_SIZE_POS = 6;
	localparam int LOWPRI_BIT = 5;
	localparam int IOAPIC_BIT = 4;
	localparam int MSI_BIT = 3;
	localparam int TSM_EN_BIT = 2;
	localparam int SDIO_BIT = 1;
	localparam int CSMM_BIT = 0;

	// Shadow access control encoding.
	localparam logic [1:0] SHD_NONE = 2'b00;
	localparam logic [1:0] SHD_WR = 2'b01;
	localparam logic [1:0] SHD_RD = 2'b10;
	localparam logic [1:0] SHD_RW = 2'b11;

	// Memory hole encoding.
	localparam logic [1:0] HOLE_NONE = 2'b00;
	localparam logic [1:0] HOLE_CONV_TOP = 2'b01;
	localparam logic [1:0] HOLE_ONE_MEG = 2'b10;
	localparam logic [1:0] HOLE_TWO_MEG = 2'b11;

	// Decode windows, compared on the named address slices.
	localparam logic [11:0] LOW_MEG_TAG = 12'h000;
	localparam logic [2:0] PAGE_AB_TAG = 3'h5;
	localparam logic [3:0] PAGE_C_TAG = 4'hC;
	localparam logic [3:0] PAGE_D_TAG = 4'hD;
	localparam logic [3:0] PAGE_E_TAG = 4'hE;
	localparam logic [3:0] PAGE_F_TAG = 4'hF;
	localparam logic [12:0] CONV_TOP_TAG = 13'h0001;
	localparam logic [7:0] ONE_MEG_HOLE_TAG = 8'h0F;
	localparam logic [6:0] TWO_MEG_HOLE_TAG = 7'h07;
	localparam logic [11:0] IOAPIC_TAG = 12'hFEC;
	localparam logic [11:0] MSI_TAG = 12'hFEE;
	localparam int IOAPIC_SPLIT_BIT = 19;
	localparam int MEG_SHIFT = 20;

	// Routing targets, one-hot.
	typedef enum logic [3:0] {
		TGT_DRAM = 4'b0001,
		TGT_FIRST_BUS = 4'b0010,
		TGT_SECOND_BUS = 4'b0100,
		TGT_HOST_SNOOP = 4'b1000
	} hmd_tgt_t;

	// One host or master request.
	typedef struct packed {
		logic vld;
		logic [31:0] addr;
		logic wr;
		logic code;
		logic smm;
		logic master;
	} hmd_req_t;

	// The routing answer for one request.
	typedef struct packed {
		logic vld;
		hmd_tgt_t tgt;
		logic claim;
	} hmd_rsp_t;

endpackage

// *** rtl/hmd_shadow_chk.sv ***
/*
 * Checks one two-bit shadow access control against the direction of a
 * cycle and says whether DRAM may take it.
 * Assumes the control was already picked for the addressed segment.
 */
`timescale 1ns/1ps
`default_nettype none

module hmd_shadow_chk (
	input wire logic [1:0] ctrl_i, // Segment access control.
	input wire logic wr_i, // High for a write cycle.
	output logic dram_o // High when DRAM takes the cycle.
);

	// Read permission sits in the upper bit, write in the lower one.
	logic rd_ok;
	logic wr_ok;

	// Decode the shared encoding: none, write, read, both.
	always_comb
	begin
		unique case (ctrl_i)
			hmd_pkg::SHD_NONE:
			begin
				rd_ok = 1'b0;
				wr_ok = 1'b0;
			end
			hmd_pkg::SHD_WR:
			begin
				rd_ok = 1'b0;
				wr_ok = 1'b1;
			end
			hmd_pkg::SHD_RD:
			begin
				rd_ok = 1'b1;
				wr_ok = 1'b0;
			end
			hmd_pkg::SHD_RW:
			begin
				rd_ok = 1'b1;
				wr_ok = 1'b1;
			end
		endcase
	end

	// Pick the permission that matches the direction.
	assign dram_o = wr_i ? wr_ok : rd_ok;

endmodule

`default_nettype wire

// *** rtl/hmd_host_decoder.sv ***
/*
 * Host memory space decoder: holds the shadow, hole, SMRAM, low top,
 * top SM memory and APIC decode registers, and routes each request to
 * DRAM, the first or second downstream bus or the host snoop path.
 * Assumes a byte-wide configuration port synchronous to REF_CLK_I and
 * requests that present all fields in the cycle in which vld is high.
 */
`timescale 1ns/1ps
`default_nettype none

module hmd_host_decoder #(
	parameter int LAST_W = 11 // Width of the last DRAM address field.
) (
	input wire logic REF_CLK_I, // Host clock, 40 MHz.
	input wire logic SYS_RST_I, // Synchronous reset, active high.
	input wire logic [7:0] CFG_ADDR_I, // Configuration byte offset.
	input wire logic CFG_WR_I, // Configuration write strobe.
	input wire logic CFG_RD_I, // Configuration read strobe.
	input wire logic [7:0] CFG_WDATA_I, // Configuration write data.
	output logic [7:0] CFG_RDATA_O, // Read data, one cycle after strobe.
	output logic CFG_RVLD_O, // Read data valid pulse.
	input wire logic [LAST_W-1:0] LAST_DRAM_I, // Sized DRAM end.
	input wire hmd_pkg::hmd_req_t REQ_I, // Request to be routed.
	output hmd_pkg::hmd_rsp_t RSP_O, // Routing answer, one cycle later.
	output logic LOWPRI_ARB_EN_O, // Lowest priority arbitration enable.
	output logic SDIO_SYSMEM_O, // SDIO system memory enable.
	output logic COMPAT_SMM_O // Compatible SMM enable.
);

	// Configuration registers.
	logic [7:0] page_c_shadow_ctrl_ff; // Page C segment controls.
	logic [7:0] page_d_shadow_ctrl_ff; // Page D segment controls.
	logic [7:0] page_e_shadow_ctrl_ff; // Page E segment controls.
	logic [7:0] page_f_hole_smram_decode_ff; // Page F, hole, SMRAM.
	logic [7:0] low_top_addr_low_ff; // Low top address bits 23:20.
	logic [7:0] low_top_addr_high_ff; // Low top address bits 31:24.
	logic [7:0] smm_apic_decode_ff; // SMM and APIC decode controls.
	logic [LAST_W-1:0] last_dram_addr_next_ff; // Last DRAM address.
	logic [7:0] rdata_ff; // Registered read data.
	logic rvld_ff; // Registered read valid.
	hmd_pkg::hmd_rsp_t rsp_ff; // Registered routing answer.
	hmd_pkg::hmd_rsp_t nxt_rsp; // Next routing answer.
	logic [7:0] nxt_rdata; // Next read data.

	// Write strobes per register.
	logic wr_c;
	logic wr_d;
	logic wr_e;
	logic wr_f;
	logic wr_lo;
	logic wr_hi;
	logic wr_smm;

	// Address slices of the request.
	logic [31:0] addr;
	logic low_meg; // Address within the first megabyte.
	logic in_ab; // Page A/B SMRAM window.
	logic in_c;
	logic in_d;
	logic in_e;
	logic in_f;
	logic in_cde; // Any 16 KB shadow segment.
	logic [7:0] page_sel; // Controls of the addressed page.
	logic [1:0] seg_ctrl; // Control of the addressed segment.
	logic [1:0] f_ctrl; // Control of the whole page F.
	logic [1:0] shd_ctrl; // Control handed to the checker.
	logic shd_dram; // Checker says DRAM takes it.
	logic in_hole; // Address falls in the enabled hole.
	logic in_ioapic; // I/O APIC window.
	logic in_msi; // Message interrupt window.
	logic [31:0] low_top; // Low top boundary.
	logic [32:0] tsm_size; // Top SM memory size in bytes.
	logic [32:0] tsm_base; // Top SM memory base.
	logic in_tsm; // Inside the enabled top SM memory.
	logic above_top; // At or above the low top boundary.
	logic ab_dram_en; // Page A/B DRAM enable.
	logic ab_data_pci; // SMM data redirect to PCI.

	// Picks a two-bit control out of a register by index.
	function automatic logic [1:0] get_pair(
		input logic [7:0] regv,
		input logic [1:0] idx
	);
		get_pair = regv[{idx, 1'b0} +: 2];
	endfunction

	// Tells whether an address falls in the hole picked by a code.
	function automatic logic hole_hit(
		input logic [1:0] sel,
		input logic [31:0] a
	);
		logic hit;
		hit = 1'b0;
		unique case (sel)
			hmd_pkg::HOLE_NONE: hit = 1'b0;
			hmd_pkg::HOLE_CONV_TOP:
				hit = (a[31:19] == hmd_pkg::CONV_TOP_TAG);
			hmd_pkg::HOLE_ONE_MEG:
				hit = (a[31:20] == {4'h0, hmd_pkg::ONE_MEG_HOLE_TAG});
			hmd_pkg::HOLE_TWO_MEG:
				hit = (a[31:21] == {4'h0, hmd_pkg::TWO_MEG_HOLE_TAG});
		endcase
		hole_hit = hit;
	endfunction

	// Decode the configuration write strobes.
	assign wr_c = CFG_WR_I && (CFG_ADDR_I == hmd_pkg::OFS_PAGE_C);
	assign wr_d = CFG_WR_I && (CFG_ADDR_I == hmd_pkg::OFS_PAGE_D);
	assign wr_e = CFG_WR_I && (CFG_ADDR_I == hmd_pkg::OFS_PAGE_E);
	assign wr_f = CFG_WR_I && (CFG_ADDR_I == hmd_pkg::OFS_PAGE_F);
	assign wr_lo = CFG_WR_I && (CFG_ADDR_I == hmd_pkg::OFS_LTOP_LO);
	assign wr_hi = CFG_WR_I && (CFG_ADDR_I == hmd_pkg::OFS_LTOP_HI);
	assign wr_smm = CFG_WR_I && (CFG_ADDR_I == hmd_pkg::OFS_SMM_APIC);

	// Shadow page registers take whole bytes.
	always_ff @(posedge REF_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			page_c_shadow_ctrl_ff <= hmd_pkg::RST_PAGE;
			page_d_shadow_ctrl_ff <= hmd_pkg::RST_PAGE;
			page_e_shadow_ctrl_ff <= hmd_pkg::RST_PAGE;
		end
		else
		begin
			if (wr_c)
				page_c_shadow_ctrl_ff <= CFG_WDATA_I;
			if (wr_d)
				page_d_shadow_ctrl_ff <= CFG_WDATA_I;
			if (wr_e)
				page_e_shadow_ctrl_ff <= CFG_WDATA_I;
		end
	end

	// Page F and low top low keep only their writable bits.
	always_ff @(posedge REF_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			page_f_hole_smram_decode_ff <= hmd_pkg::RST_PAGE_F;
			low_top_addr_low_ff <= hmd_pkg::RST_LTOP_LO;
		end
		else
		begin
			if (wr_f)
				page_f_hole_smram_decode_ff <=
					CFG_WDATA_I & hmd_pkg::MSK_PAGE_F;
			if (wr_lo)
				low_top_addr_low_ff <=
					CFG_WDATA_I & hmd_pkg::MSK_LTOP_LO;
		end
	end

	// Low top high byte and the SMM and APIC decode byte.
	always_ff @(posedge REF_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			low_top_addr_high_ff <= hmd_pkg::RST_LTOP_HI;
			smm_apic_decode_ff <= hmd_pkg::RST_SMM_APIC;
		end
		else
		begin
			if (wr_hi)
				low_top_addr_high_ff <= CFG_WDATA_I;
			if (wr_smm)
				smm_apic_decode_ff <= CFG_WDATA_I;
		end
	end

	// The last DRAM address follows the sizing logic; software
	// cannot write it.
	always_ff @(posedge REF_CLK_I)
	begin
		if (SYS_RST_I)
			last_dram_addr_next_ff <= hmd_pkg::RST_LAST[LAST_W-1:0];
		else
			last_dram_addr_next_ff <= LAST_DRAM_I;
	end

	// Read multiplexer; unmapped offsets and reserved bits read zero.
	always_comb
	begin
		nxt_rdata = 8'h00;
		unique case (CFG_ADDR_I)
			hmd_pkg::OFS_PAGE_C: nxt_rdata = page_c_shadow_ctrl_ff;
			hmd_pkg::OFS_PAGE_D: nxt_rdata = page_d_shadow_ctrl_ff;
			hmd_pkg::OFS_PAGE_E: nxt_rdata = page_e_shadow_ctrl_ff;
			hmd_pkg::OFS_PAGE_F:
				nxt_rdata = page_f_hole_smram_decode_ff;
			hmd_pkg::OFS_LTOP_LO: nxt_rdata = low_top_addr_low_ff;
			hmd_pkg::OFS_LTOP_HI: nxt_rdata = low_top_addr_high_ff;
			hmd_pkg::OFS_SMM_APIC: nxt_rdata = smm_apic_decode_ff;
			hmd_pkg::OFS_LAST_LO:
				nxt_rdata = last_dram_addr_next_ff[7:0];
			hmd_pkg::OFS_LAST_HI:
				nxt_rdata = {5'h00,
					last_dram_addr_next_ff[LAST_W-1:8]};
			default: nxt_rdata = 8'h00;
		endcase
	end

	// Read data is registered so it stands a cycle after the strobe.
	always_ff @(posedge REF_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			rdata_ff <= 8'h00;
			rvld_ff <= 1'b0;
		end
		else
		begin
			rdata_ff <= CFG_RD_I ? nxt_rdata : rdata_ff;
			rvld_ff <= CFG_RD_I;
		end
	end

	// Control bits that leave the block as levels.
	assign LOWPRI_ARB_EN_O = smm_apic_decode_ff[hmd_pkg::LOWPRI_BIT];
	assign SDIO_SYSMEM_O = smm_apic_decode_ff[hmd_pkg::SDIO_BIT];
	assign COMPAT_SMM_O = smm_apic_decode_ff[hmd_pkg::CSMM_BIT];

	// Legacy area windows in the first megabyte.
	assign addr = REQ_I.addr;
	assign low_meg = (addr[31:20] == hmd_pkg::LOW_MEG_TAG);
	assign in_ab = low_meg && (addr[19:17] == hmd_pkg::PAGE_AB_TAG);
	assign in_c = low_meg && (addr[19:16] == hmd_pkg::PAGE_C_TAG);
	assign in_d = low_meg && (addr[19:16] == hmd_pkg::PAGE_D_TAG);
	assign in_e = low_meg && (addr[19:16] == hmd_pkg::PAGE_E_TAG);
	assign in_f = low_meg && (addr[19:16] == hmd_pkg::PAGE_F_TAG);
	assign in_cde = in_c || in_d || in_e;

	// Select the page and the 16 KB segment; bits 15:14 count up from
	// the lowest segment, which sits in bits 1:0.
	assign page_sel = in_c ? page_c_shadow_ctrl_ff :
		in_d ? page_d_shadow_ctrl_ff :
		page_e_shadow_ctrl_ff;
	assign seg_ctrl = get_pair(page_sel, addr[15:14]);
	assign f_ctrl = get_pair(page_f_hole_smram_decode_ff,
		2'(hmd_pkg::F_CTRL_POS / 2));
	assign shd_ctrl = in_f ? f_ctrl : seg_ctrl;

	// One checker serves the 16 KB segments and page F alike.
	hmd_shadow_chk u_shadow_chk (
		.ctrl_i(shd_ctrl),
		.wr_i(REQ_I.wr),
		.dram_o(shd_dram)
	);

	// Memory hole, SMRAM and APIC window decode.
	assign in_hole = hole_hit(
		page_f_hole_smram_decode_ff[hmd_pkg::HOLE_POS +: 2],
		addr);
	assign ab_dram_en =
		page_f_hole_smram_decode_ff[hmd_pkg::AB_DRAM_BIT];
	assign ab_data_pci =
		page_f_hole_smram_decode_ff[hmd_pkg::SMM_DATA_PCI_BIT];
	assign in_ioapic = (addr[31:20] == hmd_pkg::IOAPIC_TAG);
	assign in_msi = (addr[31:20] == hmd_pkg::MSI_TAG);

	// Low top boundary; bits below 20 are always zero.
	assign low_top = {low_top_addr_high_ff,
		low_top_addr_low_ff[7:4], 20'h0_0000};

	// Top SM memory sits just below the low top; 1M shifted by size.
	assign tsm_size = 33'h0_0010_0000 <<
		smm_apic_decode_ff[hmd_pkg::TSM_SIZE_POS +: 2];
	assign tsm_base = {1'b0, low_top} - tsm_size;
	assign in_tsm = smm_apic_decode_ff[hmd_pkg::TSM_EN_BIT] &&
		({1'b0, addr} >= tsm_base) && (addr < low_top);
	assign above_top = (addr >= low_top);

	// Routing decision; windows are checked from most to least
	// specific so a legacy hit of a host cycle never falls through to the low top.
	always_comb
	begin
		nxt_rsp.vld = REQ_I.vld;
		nxt_rsp.tgt = hmd_pkg::TGT_DRAM;
		nxt_rsp.claim = 1'b1;
		if (REQ_I.master)
		begin
			// Bus master cycles only meet the message window and the low top here.
			if (in_msi && smm_apic_decode_ff[hmd_pkg::MSI_BIT])
				nxt_rsp.tgt = hmd_pkg::TGT_HOST_SNOOP;
			else if (in_msi)
			begin
				nxt_rsp.tgt = hmd_pkg::TGT_FIRST_BUS;
				nxt_rsp.claim = 1'b0;
			end
			else if (above_top)
				nxt_rsp.tgt = hmd_pkg::TGT_FIRST_BUS;
		end
		else if (in_ab)
		begin
			// SMRAM flow: enable wins, then mode, then code or data.
			if (ab_dram_en)
				nxt_rsp.tgt = hmd_pkg::TGT_DRAM;
			else if (!REQ_I.smm)
				nxt_rsp.tgt = hmd_pkg::TGT_FIRST_BUS;
			else if (REQ_I.code)
				nxt_rsp.tgt = hmd_pkg::TGT_DRAM;
			else if (ab_data_pci)
				nxt_rsp.tgt = hmd_pkg::TGT_FIRST_BUS;
			else
				nxt_rsp.tgt = hmd_pkg::TGT_DRAM;
		end
		else if (in_cde || in_f)
		begin
			// Shadow segments: refused directions go to the ROM.
			nxt_rsp.tgt = shd_dram ? hmd_pkg::TGT_DRAM :
				hmd_pkg::TGT_FIRST_BUS;
		end
		else if (in_hole)
			nxt_rsp.tgt = hmd_pkg::TGT_FIRST_BUS;
		else if (in_ioapic)
		begin
			// Upper half goes to the second bus only when split.
			if (smm_apic_decode_ff[hmd_pkg::IOAPIC_BIT] &&
				addr[hmd_pkg::IOAPIC_SPLIT_BIT])
				nxt_rsp.tgt = hmd_pkg::TGT_SECOND_BUS;
			else
				nxt_rsp.tgt = hmd_pkg::TGT_FIRST_BUS;
		end
		else if (in_tsm)
		begin
			// Top SM memory is DRAM only for cycles issued in SMM.
			nxt_rsp.tgt = REQ_I.smm ? hmd_pkg::TGT_DRAM :
				hmd_pkg::TGT_FIRST_BUS;
		end
		else if (above_top)
			nxt_rsp.tgt = hmd_pkg::TGT_FIRST_BUS;
		else
			nxt_rsp.tgt = hmd_pkg::TGT_DRAM;
	end

	// The answer is registered and stands for exactly one cycle.
	always_ff @(posedge REF_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			rsp_ff.vld <= 1'b0;
			rsp_ff.tgt <= hmd_pkg::TGT_DRAM;
			rsp_ff.claim <= 1'b0;
		end
		else
			rsp_ff <= nxt_rsp;
	end

	// Drive the outputs from the registers.
	assign RSP_O = rsp_ff;
	assign CFG_RDATA_O = rdata_ff;
	assign CFG_RVLD_O = rvld_ff;

endmodule

`default_nettype wire

// *** test/hmd_dec_checker.sv ***
/*
 * Port checker for the host memory space decoder.
 * Assumes it is bound to the decoder top with every port by name.
 */
`timescale 1ns/1ps
`default_nettype none

module hmd_dec_checker #(
	parameter int LAST_W = 11 // Width of the last DRAM field.
) (
	input wire logic REF_CLK_I, // Host clock.
	input wire logic SYS_RST_I, // Synchronous reset.
	input wire logic [7:0] CFG_ADDR_I, // Configuration offset.
	input wire logic CFG_WR_I, // Write strobe.
	input wire logic CFG_RD_I, // Read strobe.
	input wire logic [7:0] CFG_WDATA_I, // Write data.
	input wire logic [7:0] CFG_RDATA_O, // Read data.
	input wire logic CFG_RVLD_O, // Read valid.
	input wire logic [LAST_W-1:0] LAST_DRAM_I, // Sized DRAM end.
	input wire hmd_pkg::hmd_req_t REQ_I, // Request.
	input wire hmd_pkg::hmd_rsp_t RSP_O, // Routing answer.
	input wire logic LOWPRI_ARB_EN_O, // Arbitration enable.
	input wire logic SDIO_SYSMEM_O, // SDIO enable.
	input wire logic COMPAT_SMM_O // Compatible SMM enable.
);
	logic [7:0] apic_ff; // Copy of the SMM and APIC register.
	logic split_hi; // Request would go to the second bus.
	logic [11:0] tag; // Top twelve address bits of the request.

	default clocking dc @(posedge REF_CLK_I);
	endclocking
	default disable iff (SYS_RST_I);

	assign split_hi = apic_ff[4] && REQ_I.addr[19];
	assign tag = REQ_I.addr[31:20];

	// Follows writes so the window checks know the decode bits.
	always_ff @(posedge REF_CLK_I)
	begin
		if (SYS_RST_I)
			apic_ff <= hmd_pkg::RST_SMM_APIC;
		else if (CFG_WR_I && CFG_ADDR_I == hmd_pkg::OFS_SMM_APIC)
			apic_ff <= CFG_WDATA_I;
	end

	chk_lowpri_follow: assert property (CFG_WR_I &&
		CFG_ADDR_I == 8'h86 |=> LOWPRI_ARB_EN_O == $past(CFG_WDATA_I[5]))
		else $error("arbitration enable does not follow its bit");
	chk_ioapic_split: assert property (REQ_I.vld &&
		!REQ_I.master && tag == 12'hFEC |=> RSP_O.tgt == ($past(split_hi)
		? hmd_pkg::TGT_SECOND_BUS : hmd_pkg::TGT_FIRST_BUS))
		else $error("interrupt controller window misrouted");
	chk_msi_route: assert property (REQ_I.vld &&
		REQ_I.master && tag == 12'hFEE |=> RSP_O.claim == $past(apic_ff[3]))
		else $error("message window claim wrong");
	chk_smm_code: assert property (REQ_I.vld && !REQ_I.master &&
		REQ_I.smm && REQ_I.code && REQ_I.addr[31:17] == 15'h0005
		|=> RSP_O.tgt == hmd_pkg::TGT_DRAM)
		else $error("system management code fetch not sent to DRAM");
	chk_last_hi_zero: assert property (CFG_RD_I &&
		CFG_ADDR_I == 8'h89 |=> CFG_RDATA_O[7:3] == 5'h00)
		else $error("upper last address bits not zero");
	chk_ltop_lo_mask: assert property (CFG_RD_I &&
		CFG_ADDR_I == 8'h84 |=> CFG_RDATA_O[3:0] == 4'h0)
		else $error("low top reserved bits not zero");
	chk_page_f_mask: assert property (CFG_RD_I &&
		CFG_ADDR_I == 8'h83 |=> CFG_RDATA_O[7:6] == 2'h0)
		else $error("page F reserved bits not zero");
	chk_route_onehot: assert property (REQ_I.vld
		|=> RSP_O.vld ##0 $onehot(RSP_O.tgt))
		else $error("answer missing or target not one-hot");
endmodule

`default_nettype wire

// *** test/hmd_host_model.sv ***
/*
 * Host bus requester model: presents one request per call.
 * Assumes the caller invokes its tasks just after a falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module hmd_host_model (
	output var hmd_pkg::hmd_req_t req_o // Request toward the decoder.
);
	// Idle bus at time zero.
	initial req_o = '0;

	// Drives a valid request; f is {wr, code, smm, master}.
	task automatic issue(input logic [31:0] a, input logic [3:0] f);
		req_o = {1'h1, a, f};
	endtask

	// Drops valid and inverts the address; the four flag bits keep their values.
	task automatic quiet();
		req_o.vld = 1'h0;
		req_o.addr = ~req_o.addr;
	endtask
endmodule

`default_nettype wire

// *** test/tb_top.sv ***
/*
 * Self-checking bench of the host memory space decoder.
 * Assumes the package, the decoder, the host model and the checker.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	localparam int LAST_W = 11; // Width of the last DRAM field.
	localparam hmd_pkg::hmd_tgt_t t_dr = hmd_pkg::TGT_DRAM; // DRAM.
	localparam hmd_pkg::hmd_tgt_t t_fb = hmd_pkg::TGT_FIRST_BUS; // Bus 1.
	localparam hmd_pkg::hmd_tgt_t t_sb = hmd_pkg::TGT_SECOND_BUS; // Bus 2.
	localparam hmd_pkg::hmd_tgt_t t_hs = hmd_pkg::TGT_HOST_SNOOP; // Snoop.
	localparam logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'hFF, 8'h03, 8'h00, 8'h04, 8'h00}; // Reset reads of 80 to 89.
	logic clk = 1'h0; // Host clock.
	logic rst = 1'h1; // Synchronous reset.
	logic [7:0] c_addr = 8'h00; // Configuration offset.
	logic c_wr = 1'h0; // Write strobe.
	logic c_rd = 1'h0; // Read strobe.
	logic [7:0] c_wdata = 8'h00; // Write data.
	logic [7:0] c_rdata; // Read data.
	logic c_rvld; // Read valid.
	logic [10:0] last_dram = 11'h004; // Sized DRAM end.
	wire [2:0] lvl; // Level outputs, one port on each bit.
	hmd_pkg::hmd_req_t req; // Request from the host model.
	hmd_pkg::hmd_rsp_t rsp; // Routing answer.
	logic [7:0] rdq [$]; // Expected read data.
	hmd_pkg::hmd_rsp_t rsq [$]; // Expected answers.
	logic [31:0] seed = 32'h0000_90F3; // Random state.
	logic [31:0] r; // Current random word.
	logic [7:0] shd [4]; // Copies of the page C to F registers.
	logic [1:0] ct; // Control picked for a segment.
	int failures = 0;
	int compares = 0;

	always #12.5 clk = ~clk;

	hmd_host_model i_host (.req_o(req));

	hmd_host_decoder #(.LAST_W(LAST_W)) i_dut (
		.REF_CLK_I(clk), .SYS_RST_I(rst), .CFG_ADDR_I(c_addr),
		.CFG_WR_I(c_wr), .CFG_RD_I(c_rd), .CFG_WDATA_I(c_wdata),
		.CFG_RDATA_O(c_rdata), .CFG_RVLD_O(c_rvld),
		.LAST_DRAM_I(last_dram), .REQ_I(req), .RSP_O(rsp),
		.LOWPRI_ARB_EN_O(lvl[2]), .SDIO_SYSMEM_O(lvl[1]),
		.COMPAT_SMM_O(lvl[0])
	);

	// Xorshift source of the random stimulus.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check_rd(input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR read data expected %h seen %h", e, g);
		end
	endtask

	task automatic check_rsp(input logic [5:0] e, input logic [5:0] g);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR route expected %h seen %h", e, g);
		end
	endtask

	// One configuration cycle; a read notes its expected data.
	task automatic cfg(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		i_host.quiet();
		c_wr = w;
		c_rd = !w;
		c_addr = a;
		c_wdata = d;
		if (!w)
			rdq.push_back(d);
	endtask

	// One request cycle; claim drops only for an unclaimed message.
	task automatic rt(input logic [31:0] a, input logic [3:0] f,
		input hmd_pkg::hmd_tgt_t t);
		@(negedge clk);
		c_wr = 1'h0;
		c_rd = 1'h0;
		i_host.issue(a, f);
		rsq.push_back({1'h1, t, !(f[0] && t == t_fb && a[31:20] == 12'hFEE)});
	endtask

	// Compares each result against the oldest note once settled.
	always @(negedge clk)
	begin
		if (!rst && c_rvld === 1'h1)
			check_rd(rdq.size() != 0 ? rdq.pop_front() : 8'hxx, c_rdata);
		if (!rst && rsp.vld === 1'h1)
			check_rsp(rsq.size() != 0 ? rsq.pop_front() : 6'hxx, rsp);
	end

	// Cuts a hang short.
	initial
	begin
		repeat (5000) @(posedge clk);
		failures++;
		complete_run();
	end

	initial
	begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst = 1'h0;
		check_rd(8'h03, {5'h00, lvl});
		for (int i = 0; i < 10; i++)
			cfg(1'h0, 8'(8'h80 + i), rv[i]);
		last_dram = 11'(rnd());
		cfg(1'h1, 8'h88, 8'hFF);
		cfg(1'h0, 8'h88, last_dram[7:0]);
		cfg(1'h0, 8'h89, {5'h00, last_dram[10:8]});
		cfg(1'h1, 8'h83, 8'hFF);
		cfg(1'h0, 8'h83, 8'h3F);
		cfg(1'h1, 8'h84, 8'hFF);
		cfg(1'h0, 8'h84, 8'hF0);
		cfg(1'h1, 8'h8A, 8'h5A);
		cfg(1'h0, 8'h8A, 8'h00);
		// Every hole code against an address inside each hole.
		for (int h = 0; h < 4; h++)
		begin
			cfg(1'h1, 8'h83, 8'(h << 2));
			rt(32'h0009_0000, 4'h0, h == 1 ? t_fb : t_dr);
			rt(32'h00F0_8000, 4'h8, h >= 2 ? t_fb : t_dr);
			rt(32'h00E0_0000, 4'h0, h == 3 ? t_fb : t_dr);
		end
		// Page A/B flow for each redirect, enable, mode and kind.
		for (int k = 0; k < 4; k++)
		begin
			cfg(1'h1, 8'h83, 8'(k));
			for (int j = 0; j < 4; j++)
				rt(32'h000A_8000, {1'h0, j[0], j[1], 1'h0},
					k[0] ? t_dr : !j[1] ? t_fb : j[0] ? t_dr :
					k[1] ? t_fb : t_dr);
		end
		// Random shadow controls and random segment accesses.
		for (int n = 0; n < 6; n++)
		begin
			for (int p = 0; p < 4; p++)
			begin
				shd[p] = 8'(rnd()) & (p == 3 ? 8'h30 : 8'hFF);
				cfg(1'h1, 8'(8'h80 + p), shd[p]);
				cfg(1'h0, 8'(8'h80 + p), shd[p]);
			end
			for (int q = 0; q < 8; q++)
			begin
				r = rnd();
				ct = r[1:0] == 2'h3 ? shd[3][5:4] : shd[r[1:0]][r[3:2] * 2 +: 2];
				rt({12'h000, 4'hC + {2'h0, r[1:0]}, r[3:2], r[29:16]},
					{r[4], r[6:5], 1'h0}, (r[4] ? ct[0] : ct[1]) ? t_dr : t_fb);
			end
		end
		// Low top at 4080_0000h with each top SM memory size.
		cfg(1'h1, 8'h85, 8'h40);
		cfg(1'h1, 8'h84, 8'h80);
		for (int s = 0; s < 4; s++)
		begin
			cfg(1'h1, 8'h86, 8'(s << 6) | 8'h07);
			r = 32'h4080_0000 - (32'h0010_0000 << s);
			rt(r, 4'h0, t_fb);
			rt(r, 4'h2, t_dr);
			rt(r - 4, 4'h0, t_dr);
			rt(32'h4080_0000, 4'h2, t_fb);
		end
		cfg(1'h1, 8'h86, 8'h23);
		rt(32'h407F_FFFC, 4'h0, t_dr);
		check_rd(8'h07, {5'h00, lvl});
		// Interrupt controller and message windows for all settings.
		for (int k = 0; k < 4; k++)
		begin
			cfg(1'h1, 8'h86, 8'(k << 3));
			rt(32'hFEC0_1000, 4'h0, t_fb);
			rt(32'hFEC8_0000, 4'h8, k[1] ? t_sb : t_fb);
			rt(32'hFEE0_0000, 4'h1, k[0] ? t_hs : t_fb);
			rt(32'hFEE0_0000, 4'h0, t_fb);
		end
		cfg(1'h1, 8'h87, 8'h00);
		repeat (3) @(negedge clk);
		if (rdq.size() != 0 || rsq.size() != 0)
			failures++;
		complete_run();
	end
endmodule

bind hmd_host_decoder hmd_dec_checker #(.LAST_W(LAST_W)) i_chk (
	.REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .CFG_ADDR_I(CFG_ADDR_I),
	.CFG_WR_I(CFG_WR_I), .CFG_RD_I(CFG_RD_I), .CFG_WDATA_I(CFG_WDATA_I),
	.CFG_RDATA_O(CFG_RDATA_O), .CFG_RVLD_O(CFG_RVLD_O),
	.LAST_DRAM_I(LAST_DRAM_I), .REQ_I(REQ_I), .RSP_O(RSP_O),
	.LOWPRI_ARB_EN_O(LOWPRI_ARB_EN_O), .SDIO_SYSMEM_O(SDIO_SYSMEM_O),
	.COMPAT_SMM_O(COMPAT_SMM_O)
);

`default_nettype wire
